// >>> rtl/ulf_defines.vh
/*
  Constants of the line-format and modem-control block: register
  offsets, field positions, reset values and prescaler counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ULF_DEFINES_VH
`define ULF_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets on the internal register port
// ----------------------------------------------------------------
`define ULF_ADDR_W          3
`define ULF_OFS_DATA_DLL    3'h0
`define ULF_OFS_IER_DLM     3'h1
`define ULF_OFS_LFC         3'h3
`define ULF_OFS_MLC         3'h4

// ----------------------------------------------------------------
// Line-format control fields
// ----------------------------------------------------------------
`define ULF_LFC_DLAB        7
`define ULF_LFC_BREAK       6
`define ULF_LFC_FORCE       5
`define ULF_LFC_PTYPE       4
`define ULF_LFC_PEN         3
`define ULF_LFC_STOP        2
`define ULF_LFC_WLEN_HI     1
`define ULF_LFC_WLEN_LO     0
`define ULF_LFC_RST         8'h00

// ----------------------------------------------------------------
// Modem-control fields
// ----------------------------------------------------------------
`define ULF_MLC_PRESC       7
`define ULF_MLC_IRDA        6
`define ULF_MLC_XANY        5
`define ULF_MLC_TCR_EN      2
`define ULF_MLC_RST         8'h00
`define ULF_DIV_RST         8'h00

// ----------------------------------------------------------------
// Character format values
// ----------------------------------------------------------------
`define ULF_WLEN_5          2'h0
`define ULF_BITS_BASE       4'h5
`define ULF_STOP_HALF_1     3'h2
`define ULF_STOP_HALF_15    3'h3
`define ULF_STOP_HALF_2     3'h4

// ----------------------------------------------------------------
// Prescaler
// ----------------------------------------------------------------
`define ULF_PRESC_LAST      2'h3

`endif

// >>> rtl/ulf_prescaler.v
/*
  Reference clock prescaler: emits a baud-generator enable tick on
  every clock, or on every fourth clock when divide-by-four is set.
  Assumes the select comes from a register on the same clock.
*/
`timescale 1ns/10ps
`include "ulf_defines.vh"

module ulf_prescaler (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Control
  input  wire       div4,
  // Output tick
  output reg        tick_reg
);

  reg  [1:0] cnt_reg;
  wire [1:0] cnt_next;

  // ----------------------------------------------------------------
  // Divide by one or four
  // ----------------------------------------------------------------
  assign cnt_next = div4 ? (cnt_reg + 2'h1) : 2'h0;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 2'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= div4 ? (cnt_reg == `ULF_PRESC_LAST) : 1'b1;
    end
  end

endmodule // ulf_prescaler

// >>> rtl/ulf_line_format_control.v
/*
  Line-format control and upper modem-control bits of one UART
  channel, with the divisor latches they steer, parity generation
  and checking, break forcing and prescaler.
  Assumes a same-clock register port from the host interface and a
  transmitter, receiver and data/IER registers outside this block.
*/
`timescale 1ns/10ps
`include "ulf_defines.vh"

// Operation
// - Reset clears divisor access, break, parity enable and forced parity.
// - Line-format bit 7 enables divisor latch access when set.
// - Break bit 6 holds transmit output low until software clears it.
// - Parity enable bit 3 adds and checks parity; clear ignores bits 5, 4.
// - Unforced parity: bit 4 zero is odd, one is even.
// - Forced parity: bit 4 zero gives constant one, one gives zero.
// - Stop bit 2 clear gives one; set gives 1.5 (5-bit) or two.
// - Word length bits 1:0 select 5, 6, 7 or 8 data bits.
// - Modem bit 7 selects reference clock divide by one or four.
// - Modem bit 5 clear disables resume on any received character.
// - Modem bit 5 set resumes transmission on any received character.
// - Modem bits 7:5 change only while enhanced write enable is set.
module ulf_line_format_control (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   rst,
  // Register port
  input  wire [`ULF_ADDR_W-1:0] reg_addr,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  input  wire [7:0]             reg_wdata,
  output reg  [7:0]             reg_rdata_reg,
  // Enhanced write enable from enhanced_feature_control bit 4
  input  wire                   enh_write_en,
  // Shared low addresses toward data and interrupt-enable registers
  output wire                   ext_wr,
  output wire                   ext_rd,
  input  wire [7:0]             ext_rdata,
  // Baud divisor and prescaler
  output wire [15:0]            baud_divisor,
  output wire                   baud_tick,
  // Character format
  output reg  [3:0]             data_bits_reg,
  output reg  [2:0]             stop_half_bits_reg,
  output reg                    parity_en_reg,
  // Transmit side
  input  wire [7:0]             tx_char,
  output reg                    tx_parity_bit_reg,
  input  wire                   tx_serial,
  output reg                    tx_line_reg,
  // Receive side
  input  wire                   rx_char_valid,
  input  wire [7:0]             rx_char,
  input  wire                   rx_parity_bit,
  output reg                    rx_parity_err_reg,
  // Modes
  output wire                   irda_mode,
  input  wire                   tx_halted,
  output reg                    tx_resume_reg
);

  reg  [7:0] lfc_reg;
  reg  [7:0] mlc_reg;
  reg  [7:0] dll_reg;
  reg  [7:0] dlm_reg;
  reg  [7:0] lfc_next;
  reg  [7:0] mlc_next;
  reg  [7:0] rdata_next;
  reg  [7:0] wmask;
  reg  [3:0] bits_next;
  reg  [2:0] stop_next;
  wire       dlab;
  wire       low_addr;
  wire       hit_lfc;
  wire       hit_mlc;
  wire       hit_dll;
  wire       hit_dlm;
  wire       pen;
  wire [7:0] tx_masked;
  wire [7:0] rx_masked;
  wire       tx_par;
  wire       rx_par;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign dlab     = lfc_reg[`ULF_LFC_DLAB];
  assign low_addr = (reg_addr == `ULF_OFS_DATA_DLL) || (reg_addr == `ULF_OFS_IER_DLM);
  assign hit_lfc  = (reg_addr == `ULF_OFS_LFC);
  assign hit_mlc  = (reg_addr == `ULF_OFS_MLC);
  assign hit_dll  = dlab && (reg_addr == `ULF_OFS_DATA_DLL);
  assign hit_dlm  = dlab && (reg_addr == `ULF_OFS_IER_DLM);
  assign ext_wr   = reg_wr && low_addr && !dlab;
  assign ext_rd   = reg_rd && low_addr && !dlab;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @* begin
    lfc_next = lfc_reg;
    if (reg_wr && hit_lfc) begin
      lfc_next = reg_wdata;
    end
    wmask = enh_write_en ? 8'hFF : 8'h1B;
    mlc_next = mlc_reg;
    if (reg_wr && hit_mlc) begin
      mlc_next = (reg_wdata & wmask) | (mlc_reg & ~wmask);
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lfc_reg <= `ULF_LFC_RST;
      mlc_reg <= `ULF_MLC_RST;
      dll_reg <= `ULF_DIV_RST;
      dlm_reg <= `ULF_DIV_RST;
    end else begin
      lfc_reg <= lfc_next;
      mlc_reg <= mlc_next;
      if (reg_wr && hit_dll) begin
        dll_reg <= reg_wdata;
      end
      if (reg_wr && hit_dlm) begin
        dlm_reg <= reg_wdata;
      end
    end
  end

  assign baud_divisor = {dlm_reg, dll_reg};

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = 8'h00;
    if (hit_lfc) begin
      rdata_next = lfc_reg;
    end else if (hit_mlc) begin
      rdata_next = mlc_reg;
    end else if (hit_dll) begin
      rdata_next = dll_reg;
    end else if (hit_dlm) begin
      rdata_next = dlm_reg;
    end else if (low_addr) begin
      rdata_next = ext_rdata;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Character format
  // ----------------------------------------------------------------
  always @* begin
    bits_next = `ULF_BITS_BASE + {2'h0, lfc_reg[`ULF_LFC_WLEN_HI:`ULF_LFC_WLEN_LO]};
    if (!lfc_reg[`ULF_LFC_STOP]) begin
      stop_next = `ULF_STOP_HALF_1;
    end else if (lfc_reg[`ULF_LFC_WLEN_HI:`ULF_LFC_WLEN_LO] == `ULF_WLEN_5) begin
      stop_next = `ULF_STOP_HALF_15;
    end else begin
      stop_next = `ULF_STOP_HALF_2;
    end
  end

  // ----------------------------------------------------------------
  // Parity generation and checking
  // ----------------------------------------------------------------
  function [7:0] ulf_mask;
    input [7:0] data;
    input [1:0] wlen;
    begin
      case (wlen)
        2'h0:    ulf_mask = data & 8'h1F;
        2'h1:    ulf_mask = data & 8'h3F;
        2'h2:    ulf_mask = data & 8'h7F;
        default: ulf_mask = data;
      endcase
    end
  endfunction

  function ulf_parity;
    input [7:0] data;
    input       ptype;
    input       force_par;
    begin
      if (force_par) begin
        ulf_parity = !ptype;
      end else begin
        ulf_parity = ptype ? (^data) : !(^data);
      end
    end
  endfunction

  assign pen       = lfc_reg[`ULF_LFC_PEN];
  assign tx_masked = ulf_mask(tx_char, lfc_reg[`ULF_LFC_WLEN_HI:`ULF_LFC_WLEN_LO]);
  assign rx_masked = ulf_mask(rx_char, lfc_reg[`ULF_LFC_WLEN_HI:`ULF_LFC_WLEN_LO]);
  assign tx_par    = ulf_parity(tx_masked, lfc_reg[`ULF_LFC_PTYPE], lfc_reg[`ULF_LFC_FORCE]);
  assign rx_par    = ulf_parity(rx_masked, lfc_reg[`ULF_LFC_PTYPE], lfc_reg[`ULF_LFC_FORCE]);

  // ----------------------------------------------------------------
  // Format, line and mode outputs
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_bits_reg      <= `ULF_BITS_BASE;
      stop_half_bits_reg <= `ULF_STOP_HALF_1;
      parity_en_reg      <= 1'b0;
      tx_parity_bit_reg  <= 1'b0;
      rx_parity_err_reg  <= 1'b0;
      tx_line_reg        <= 1'b1;
      tx_resume_reg      <= 1'b0;
    end else begin
      data_bits_reg      <= bits_next;
      stop_half_bits_reg <= stop_next;
      parity_en_reg      <= pen;
      tx_parity_bit_reg  <= pen && tx_par;
      if (rx_char_valid) begin
        rx_parity_err_reg <= pen && (rx_parity_bit != rx_par);
      end
      tx_line_reg        <= lfc_reg[`ULF_LFC_BREAK] ? 1'b0 : tx_serial;
      tx_resume_reg      <= mlc_reg[`ULF_MLC_XANY] &&
                            rx_char_valid && tx_halted;
    end
  end

  assign irda_mode = mlc_reg[`ULF_MLC_IRDA];

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  ulf_prescaler u_presc (
    .core_clk (core_clk),
    .rst      (rst),
    .div4     (mlc_reg[`ULF_MLC_PRESC]),
    .tick_reg (baud_tick)
  );

endmodule // ulf_line_format_control

// >>> verification/ulf_line_format_control_asserts.sv
/* Port checker for ulf_line_format_control.
   Assumes register shadows tracking host writes, bound below. */
`timescale 1ns/10ps
`include "ulf_defines.vh"
// ----
// Checker
// ----
module ulf_lfc_checker (
  // Clock, reset and register port
  input wire core_clk, input wire rst, input wire [`ULF_ADDR_W-1:0] reg_addr,
  input wire reg_wr, input wire reg_rd, input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_reg, input wire enh_write_en, input wire ext_wr,
  // Format, line and modes
  input wire [15:0] baud_divisor, input wire baud_tick, input wire [3:0] data_bits_reg,
  input wire [2:0] stop_half_bits_reg, input wire parity_en_reg, input wire [7:0] tx_char,
  input wire tx_parity_bit_reg, input wire tx_serial, input wire tx_line_reg,
  input wire rx_char_valid, input wire [7:0] rx_char, input wire rx_parity_bit,
  input wire rx_parity_err_reg, input wire irda_mode, input wire tx_halted,
  input wire tx_resume_reg
);
  logic [7:0] lfc_sh;
  logic [7:0] mlc_sh;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic logic pf(input logic [7:0] c, input logic [7:0] f);
    logic [7:0] m;
    m = c & (8'hFF >> (2'h3 - f[1:0]));
    return f[5] ? !f[4] : (f[4] ? ^m : ~^m);
  endfunction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lfc_sh <= 8'h00;
      mlc_sh <= 8'h00;
    end else if (reg_wr && reg_addr == `ULF_OFS_LFC) lfc_sh <= reg_wdata;
    else if (reg_wr && reg_addr == `ULF_OFS_MLC && enh_write_en) mlc_sh <= reg_wdata;
  end
  sequence quarter_run_s;
    (mlc_sh[7] && $past(mlc_sh[7], 8) && baud_tick) ##1 mlc_sh[7] [*3];
  endsequence
  line_break_a: assert property (tx_line_reg == ($past(lfc_sh[6]) ? 1'b0 : $past(tx_serial)))
    else $error("line output wrong");
  word_len_a: assert property (data_bits_reg == 4'h5 + $past(lfc_sh[1:0]))
    else $error("data bits wrong");
  stop_len_a: assert property (stop_half_bits_reg == (!$past(lfc_sh[2]) ? 3'h2 :
    ($past(lfc_sh[1:0]) == 2'h0 ? 3'h3 : 3'h4))) else $error("stop length wrong");
  parity_en_a: assert property (parity_en_reg == $past(lfc_sh[3]))
    else $error("parity enable wrong");
  tx_parity_a: assert property (tx_parity_bit_reg == $past(lfc_sh[3] & pf(tx_char, lfc_sh)))
    else $error("tx parity wrong");
  rx_check_a: assert property (rx_char_valid |=> rx_parity_err_reg ==
    $past(lfc_sh[3] && rx_parity_bit != pf(rx_char, lfc_sh))) else $error("rx check wrong");
  ext_gate_a: assert property (ext_wr == (reg_wr && reg_addr < 3'h2 && !lfc_sh[7]))
    else $error("data write not steered");
  div_read_a: assert property (reg_rd && reg_addr < 3'h2 && lfc_sh[7] |=> reg_rdata_reg ==
    $past(reg_addr[0] ? baud_divisor[15:8] : baud_divisor[7:0])) else $error("divisor read");
  irda_sel_a: assert property (irda_mode == mlc_sh[6])
    else $error("line mode wrong");
  full_tick_a: assert property (!$past(mlc_sh[7]) && !$past(mlc_sh[7], 2) && !$past(rst)
    && !$past(rst, 2) |-> baud_tick) else $error("tick missing");
  quarter_tick_a: assert property (quarter_run_s |->
    (!$past(baud_tick) && !$past(baud_tick, 2) && !baud_tick) ##1 baud_tick)
    else $error("quarter tick wrong");
  resume_a: assert property (tx_resume_reg == $past(rx_char_valid && tx_halted && mlc_sh[5]))
    else $error("resume wrong");
endmodule // ulf_lfc_checker
bind ulf_line_format_control ulf_lfc_checker chk (.*);

// >>> verification/ulf_term_model.sv
/* Remote terminal: sends characters with parity in the agreed format.
   Assumes the bench sets the format and calls send. */
`timescale 1ns/10ps
// ----
// Terminal
// ----
module ulf_term_model (
  input  wire        core_clk,
  input  wire  [7:0] fmt,
  output logic       rx_char_valid,
  output logic [7:0] rx_char,
  output logic       rx_parity_bit
);
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    rx_parity_bit = 1'b0;
  end
  task automatic send(input logic [7:0] c, input logic bad);
    logic [7:0] m;
    @(negedge core_clk);
    m = c & (8'hFF >> (2'h3 - fmt[1:0]));
    rx_char = c;
    rx_parity_bit = bad ^ (fmt[5] ? !fmt[4] : (fmt[4] ? ^m : ~^m));
    rx_char_valid = 1'b1;
    @(negedge core_clk);
    rx_char_valid = 1'b0;
    rx_char = ~c;
    rx_parity_bit = ~rx_parity_bit;
  endtask
endmodule // ulf_term_model

// >>> verification/ulf_line_format_control_bench.sv
/* Bench for ulf_line_format_control with terminal model.
   Assumes the design and checker files are compiled first. */
`timescale 1ns/10ps
// ----
// Bench
// ----
module ulf_line_format_control_bench;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, enh_write_en = 1'b0;
  logic tx_serial = 1'b1, tx_halted = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, ext_rdata = 8'h5A, tx_char = 8'h35, fmt = 8'h00, rd_val;
  logic ext_seen = 1'b0;
  wire rx_char_valid, rx_parity_bit, ext_wr, ext_rd, baud_tick, parity_en_reg;
  wire tx_parity_bit_reg, tx_line_reg, rx_parity_err_reg, irda_mode, tx_resume_reg;
  wire [7:0] rx_char, reg_rdata_reg;
  wire [15:0] baud_divisor;
  wire [3:0] data_bits_reg;
  wire [2:0] stop_half_bits_reg;
  int fail_count = 0, compares = 0, cyc = 0, i, n;
  logic [16:0] rows [11] = '{17'h000A8, 17'h00AD0, 17'h00CF0, 17'h00F10, 17'h008AC,
    17'h010AA, 17'h030AB, 17'h0370A, 17'h050AB, 17'h070AA, 17'h060A8};
  ulf_line_format_control uut (.*);
  ulf_term_model term (.core_clk, .fmt, .rx_char_valid, .rx_char, .rx_parity_bit);
  always #2 core_clk = ~core_clk;
  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    #1 ext_seen = ext_wr;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    #1 ext_seen = ext_rd;
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    rd_val = reg_rdata_reg;
  endtask
  task automatic ticks();
    n = 0;
    repeat (8) begin
      @(negedge core_clk);
      n += baud_tick;
    end
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    rd(3'h3);
    chk(rd_val, 16'h0000);
    rd(3'h4);
    chk(rd_val, 16'h0000);
    chk(tx_line_reg, 16'h0001);
    for (i = 0; i < 11; i++) begin
      fmt = rows[i][16:9];
      tx_serial = i[0];
      wr(3'h3, fmt);
      @(negedge core_clk);
      chk({data_bits_reg, stop_half_bits_reg, parity_en_reg, tx_parity_bit_reg}, rows[i][8:0]);
      term.send(8'hC9, 1'b0);
      chk(rx_parity_err_reg, 16'h0000);
      term.send(8'hC9, 1'b1);
      chk(rx_parity_err_reg, rows[i][1]);
    end
    tx_serial = 1'b1;
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    chk(ext_seen, 16'h0000);
    wr(3'h1, 8'h12);
    chk(baud_divisor, 16'h1234);
    rd(3'h1);
    chk(rd_val, 16'h0012);
    wr(3'h3, 8'h00);
    rd(3'h0);
    chk(rd_val, 16'h005A);
    chk(ext_seen, 16'h0001);
    rd(3'h7);
    chk(rd_val, 16'h0000);
    wr(3'h3, 8'h40);
    repeat (4) begin
      @(negedge core_clk);
      chk(tx_line_reg, 16'h0000);
    end
    wr(3'h3, 8'h00);
    @(negedge core_clk);
    chk(tx_line_reg, 16'h0001);
    wr(3'h4, 8'hE0);
    chk(irda_mode, 16'h0000);
    enh_write_en = 1'b1;
    wr(3'h4, 8'hE0);
    chk(irda_mode, 16'h0001);
    tx_halted = 1'b1;
    term.send(8'h11, 1'b0);
    chk(tx_resume_reg, 16'h0001);
    ticks();
    chk(16'(n), 16'h0002);
    wr(3'h4, 8'h00);
    term.send(8'h11, 1'b0);
    chk(tx_resume_reg, 16'h0000);
    ticks();
    chk(16'(n), 16'h0008);
    wr(3'h3, 8'h68);
    @(negedge core_clk);
    chk(tx_line_reg, 16'h0000);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    chk(tx_line_reg, 16'h0001);
    chk(parity_en_reg, 16'h0000);
    rd(3'h3);
    chk(rd_val, 16'h0000);
    tally_and_finish();
  end
endmodule // ulf_line_format_control_bench
